//--- hdl/tdpr_defines.svh
// tdpr_defines.svh: offsets, field positions and bus codes of the dual-port ram block
// assumes inclusion by bare name from the design file and the test bench
`ifndef TDPR_DEFINES_SVH
`define TDPR_DEFINES_SVH

`define TDPR_AXI_AW       12
`define TDPR_CTRL_OFS     12'h000
`define TDPR_STATUS_OFS   12'h004
`define TDPR_COUNT_OFS    12'h008
`define TDPR_CTRL_W       4
`define TDPR_STAT_COLL    0
`define TDPR_STAT_EMPTY   1
`define TDPR_STAT_FULL    2
`define TDPR_RESP_OKAY    2'h0
`define TDPR_RESP_SLVERR  2'h2
`define TDPR_CTRL_RST     4'h0
`define TDPR_MID_MAX_W    16
`define TDPR_MID_MAX_PW   18
`define TDPR_LRG_MAX_W    32
`define TDPR_LRG_MAX_PW   36
`define TDPR_PAR_UNIT     9

`endif

//--- hdl/tdpr_pkg.sv
// tdpr_pkg: types shared by the dual-port ram block
// assumes tdpr_defines.svh is available for numeric constants
package tdpr_pkg;

    // operating use of the storage array
    typedef enum logic [1:0] {
        TDPR_MODE_RAM,
        TDPR_MODE_ROM,
        TDPR_MODE_SHIFT,
        TDPR_MODE_FIFO
    } tdpr_mode_t;

    // control register layout, low bit first: out_reg, rdw_new, mode
    typedef struct packed {
        tdpr_mode_t mode;
        logic       rdw_new;
        logic       out_reg;
    } tdpr_ctrl_t;

endpackage : tdpr_pkg

//--- hdl/tdpr_ram.sv
// tdpr_ram: true dual-port ram with mixed widths, rom, shift and fifo uses,
// optional output register and configurable read-during-write, axi4-lite control
// assumes one clock aclk (single clock mode) and user logic on both ports
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "tdpr_defines.svh"

module tdpr_ram
    import tdpr_pkg::*;
#(
    parameter int DEPTH_A = 512,
    parameter int WIDTH_A = 16,
    parameter int WIDTH_B = 16,
    parameter bit LARGE   = 1'b0,
    parameter int AW_A    = $clog2(DEPTH_A),
    parameter int AW_B    = AW_A + $clog2(WIDTH_A / WIDTH_B)
) (
    // clock, reset and output clear
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     out_clr,
    // port a
    input  wire logic [AW_A-1:0]          addr_a,
    input  wire logic [WIDTH_A-1:0]       wdata_a,
    input  wire logic                     we_a,
    input  wire logic                     re_a,
    output logic      [WIDTH_A-1:0]       q_a,
    // port b
    input  wire logic [AW_B-1:0]          addr_b,
    input  wire logic [WIDTH_B-1:0]       wdata_b,
    input  wire logic                     we_b,
    input  wire logic                     re_b,
    output logic      [WIDTH_B-1:0]       q_b,
    // axi4-lite write channels
    input  wire logic [`TDPR_AXI_AW-1:0]  s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    // axi4-lite read channels
    input  wire logic [`TDPR_AXI_AW-1:0]  s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready
);

    localparam int RATIO = WIDTH_A / WIDTH_B;
    localparam int SWB   = $clog2(RATIO);
    localparam int MAXW  = LARGE ? ((WIDTH_A % `TDPR_PAR_UNIT == 0) ? `TDPR_LRG_MAX_PW
                                                                    : `TDPR_LRG_MAX_W)
                                 : ((WIDTH_A % `TDPR_PAR_UNIT == 0) ? `TDPR_MID_MAX_PW
                                                                    : `TDPR_MID_MAX_W);

    // elaboration checks: width family, ratio shape, widest port
    if ((WIDTH_A % `TDPR_PAR_UNIT == 0) != (WIDTH_B % `TDPR_PAR_UNIT == 0)) begin : g_fam
        $error("port widths mix parity and plain families");
    end
    if (WIDTH_A % WIDTH_B != 0 || (1 << SWB) != RATIO) begin : g_ratio
        $error("port a width must be a power-of-two multiple of port b width");
    end
    if (WIDTH_A > MAXW) begin : g_wide
        $error("port width exceeds the widest dual-port shape");
    end

    tdpr_ctrl_t           ctrl_q;
    logic                 coll_q;
    logic [WIDTH_A-1:0]   mem [DEPTH_A];
    logic [AW_A-1:0]      wptr_q;
    logic [AW_A-1:0]      rptr_q;
    logic [AW_A:0]        count_q;
    logic [WIDTH_A-1:0]   lat_a_q;
    logic [WIDTH_B-1:0]   lat_b_q;
    logic [WIDTH_A-1:0]   ra;
    logic [WIDTH_A-1:0]   rb_word;

    // address steering per use; shift reads tap n behind the newest entry
    wire                  m_ram    = ctrl_q.mode == TDPR_MODE_RAM;
    wire                  m_rom    = ctrl_q.mode == TDPR_MODE_ROM;
    wire                  m_shift  = ctrl_q.mode == TDPR_MODE_SHIFT;
    wire                  m_fifo   = ctrl_q.mode == TDPR_MODE_FIFO;
    wire                  f_full   = count_q == (AW_A+1)'(DEPTH_A);
    wire                  f_empty  = count_q == '0;
    wire [AW_A-1:0]       tap_b    = AW_A'(addr_b >> SWB);
    wire [7:0]            sel_b    = 8'(addr_b % RATIO);
    wire [AW_A-1:0]       word_a   = (m_shift || m_fifo) ? wptr_q : addr_a;
    wire [AW_A-1:0]       word_b   = m_shift ? AW_A'(wptr_q - tap_b - 1'b1)
                                   : m_fifo  ? rptr_q : tap_b;
    wire                  wr_a     = we_a && !m_rom && !(m_fifo && f_full);
    wire                  wr_b     = we_b && m_ram;
    wire                  rd_a     = re_a && !m_fifo;
    wire                  rd_b     = re_b && !(m_fifo && f_empty);
    wire                  collide  = wr_a && wr_b && word_a == word_b;
    wire [WIDTH_A-1:0]    mem_a    = mem[word_a];
    wire [WIDTH_B-1:0]    rb       = rb_word[sel_b*WIDTH_B +: WIDTH_B];

    // read-during-write forwarding; old-data mode simply reads the array
    always_comb begin
        ra      = mem_a;
        rb_word = mem[word_b];
        if (ctrl_q.rdw_new) begin
            if (wr_b && word_b == word_a) ra[sel_b*WIDTH_B +: WIDTH_B] = wdata_b;
            if (wr_a) ra = wdata_a;
            if (wr_a && word_a == word_b) rb_word = wdata_a;
            if (wr_b) rb_word[sel_b*WIDTH_B +: WIDTH_B] = wdata_b;
        end
    end

    // array writes; on a dual same-word write port b lands last, treat as garbage
    always_ff @(posedge aclk) begin
        if (wr_a) mem[word_a] <= wdata_a;
        if (wr_b) mem[word_b][sel_b*WIDTH_B +: WIDTH_B] <= wdata_b;
    end

    // shift and fifo pointers, input side so never touched by out_clr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wptr_q  <= '0;
            rptr_q  <= '0;
            count_q <= '0;
        end else begin
            if (wr_a && (m_shift || m_fifo)) wptr_q <= wptr_q + 1'b1;
            if (re_b && m_fifo && !f_empty) rptr_q <= rptr_q + 1'b1;
            if (m_fifo) count_q <= count_q + (AW_A+1)'(wr_a) - (AW_A+1)'(re_b && !f_empty);
            else count_q <= '0;
        end
    end

    // output stages: read latch then optional register; only these see out_clr
    always_ff @(posedge aclk or posedge out_clr) begin
        if (out_clr) begin
            lat_a_q <= '0;
            lat_b_q <= '0;
            q_a     <= '0;
            q_b     <= '0;
        end else if (!aresetn) begin
            lat_a_q <= '0;
            lat_b_q <= '0;
            q_a     <= '0;
            q_b     <= '0;
        end else begin
            // read enable low holds the last read, saving array activity
            if (rd_a) lat_a_q <= ra;
            if (rd_b) lat_b_q <= rb;
            if (ctrl_q.out_reg) begin
                q_a <= lat_a_q;
                q_b <= lat_b_q;
            end else begin
                if (rd_a) q_a <= ra;
                if (rd_b) q_b <= rb;
            end
        end
    end

    // axi4-lite slave: address and data taken in either order, then response
    logic                     aw_got_q;
    logic                     w_got_q;
    logic [`TDPR_AXI_AW-1:0]  awaddr_q;
    logic [31:0]              wdat_q;
    logic [3:0]               wstrb_q;
    wire                      do_wr    = aw_got_q && w_got_q && !s_axi_bvalid;
    wire                      wr_ctrl  = do_wr && awaddr_q == `TDPR_CTRL_OFS;
    wire                      wr_stat  = do_wr && awaddr_q == `TDPR_STATUS_OFS;
    wire                      wr_map   = wr_ctrl || wr_stat;
    wire                      clr_coll = wr_stat && wstrb_q[0] && wdat_q[`TDPR_STAT_COLL];
    wire                      ar_ok    = s_axi_araddr == `TDPR_CTRL_OFS
                                      || s_axi_araddr == `TDPR_STATUS_OFS
                                      || s_axi_araddr == `TDPR_COUNT_OFS;
    wire [31:0]               rd_mux   =
        s_axi_araddr == `TDPR_CTRL_OFS   ? 32'(ctrl_q) :
        s_axi_araddr == `TDPR_STATUS_OFS ? 32'({f_full, f_empty, coll_q}) :
        s_axi_araddr == `TDPR_COUNT_OFS  ? 32'(count_q) : 32'h0;

    // write path and registers; a collision in the clearing cycle stays set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TDPR_RESP_OKAY;
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            awaddr_q      <= '0;
            wdat_q        <= 32'h0;
            wstrb_q       <= 4'h0;
            ctrl_q        <= tdpr_ctrl_t'(`TDPR_CTRL_RST);
            coll_q        <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q      <= s_axi_awaddr;
                aw_got_q      <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdat_q       <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                w_got_q      <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? `TDPR_RESP_OKAY : `TDPR_RESP_SLVERR;
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (wr_ctrl && wstrb_q[0]) ctrl_q <= tdpr_ctrl_t'(wdat_q[`TDPR_CTRL_W-1:0]);
            coll_q <= collide || (coll_q && !clr_coll);
        end
    end

    // read path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `TDPR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= ar_ok ? `TDPR_RESP_OKAY : `TDPR_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // checks on the port behaviour
    a_new_data_a: assert property (
        @(posedge aclk) disable iff (!aresetn || out_clr)
        ctrl_q.rdw_new && !ctrl_q.out_reg && wr_a && re_a && m_ram |=> q_a == $past(wdata_a))
        else $error("new data not shown on port a");
    a_old_data_a: assert property (
        @(posedge aclk) disable iff (!aresetn || out_clr)
        !ctrl_q.rdw_new && !ctrl_q.out_reg && wr_a && re_a && m_ram |=> q_a == $past(mem_a))
        else $error("old data not shown on port a");
    a_out_reg_lag: assert property (
        @(posedge aclk) disable iff (!aresetn || out_clr)
        (re_a && m_ram && ctrl_q.out_reg && !wr_a && !wr_b) ##1 ctrl_q.out_reg
        |=> q_a == $past(mem_a, 2))
        else $error("registered output not two cycles behind");
    a_hold_idle: assert property (
        @(posedge aclk) disable iff (!aresetn || out_clr)
        !re_b && !ctrl_q.out_reg |=> $stable(q_b))
        else $error("port b output moved without read enable");
    a_coll_sticky: assert property (
        @(posedge aclk) disable iff (!aresetn)
        collide |=> coll_q ##1 (coll_q || $past(clr_coll)))
        else $error("write collision not flagged");
    a_rom_no_write: assert property (
        @(posedge aclk) disable iff (!aresetn)
        m_rom && we_a |=> mem[$past(word_a)] == $past(mem_a))
        else $error("array written in rom use");
    a_mixed_slice: assert property (
        @(posedge aclk) disable iff (!aresetn || out_clr)
        ctrl_q.rdw_new && !ctrl_q.out_reg && m_ram && wr_a && !wr_b && re_b
        && word_b == word_a |=> q_b == $past(wdata_a[sel_b*WIDTH_B +: WIDTH_B]))
        else $error("port b slice of new word wrong");
    a_fifo_bound: assert property (
        @(posedge aclk) disable iff (!aresetn)
        m_fifo && f_full && we_a |=> $stable(wptr_q))
        else $error("fifo written while full");
    a_out_clear: assert property (
        @(posedge aclk) disable iff (!aresetn)
        out_clr |-> q_a == '0 && q_b == '0)
        else $error("output clear did not zero outputs");

endmodule : tdpr_ram

//--- verif/tdpr_user_model.sv
// tdpr_user_model: user logic on both ram ports, one op per call
// assumes the bench calls op() and shares aclk with the ram
`timescale 1ns/1ps

module tdpr_user_model #(
    parameter int AW_A = 9,
    parameter int AW_B = 10,
    parameter int WA   = 16,
    parameter int WB   = 8
) (
    // clock
    input  wire logic            aclk,
    // port a
    output logic      [AW_A-1:0] addr_a,
    output logic      [WA-1:0]   wdata_a,
    output logic                 we_a,
    output logic                 re_a,
    // port b
    output logic      [AW_B-1:0] addr_b,
    output logic      [WB-1:0]   wdata_b,
    output logic                 we_b,
    output logic                 re_b
);
    logic clash_ok;

    // idle ports at time zero
    initial begin
        {addr_a, wdata_a, we_a, re_a, addr_b, wdata_b, we_b, re_b} = '0;
        clash_ok = 1'b0;
    end

    // one taken edge per op, then enables drop and data lines scramble
    task op(input logic wa, input logic ra, input logic [AW_A-1:0] aa, input logic [WA-1:0] da,
            input logic wb, input logic rb, input logic [AW_B-1:0] ab, input logic [WB-1:0] db);
        @(posedge aclk);
        addr_a  <= aa;
        wdata_a <= da;
        we_a    <= wa;
        re_a    <= ra;
        addr_b  <= ab;
        wdata_b <= db;
        re_b    <= rb;
        we_b    <= wb && (clash_ok || !wa || ab[AW_B-1:AW_B-AW_A] != aa);
        @(posedge aclk);
        we_a    <= 1'b0;
        re_a    <= 1'b0;
        we_b    <= 1'b0;
        re_b    <= 1'b0;
        wdata_a <= ~da;
        wdata_b <= ~db;
        #1;
    endtask : op
endmodule : tdpr_user_model

//--- verif/tdpr_ram_test.sv
// tdpr_ram_test: directed bench for the dual-port ram, 16-bit port a, 8-bit port b
// assumes the single clock aclk and the axi4-lite control registers of the design
`timescale 1ns/1ps
`include "tdpr_defines.svh"

module tdpr_ram_test;
    logic        aclk, aresetn, out_clr;
    logic [8:0]  addr_a;
    logic [15:0] wdata_a, q_a;
    logic [9:0]  addr_b;
    logic [7:0]  wdata_b, q_b;
    logic        we_a, re_a, we_b, re_b;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          failures, n_compared, cyc;
    // words in the default mid-size array, all of them used by the fifo fill
    localparam int DEPTH = 512;

    tdpr_ram #(.WIDTH_B(8)) i_tdpr_ram (.aclk, .aresetn, .out_clr, .addr_a, .wdata_a,
        .we_a, .re_a, .q_a, .addr_b, .wdata_b, .we_b, .re_b, .q_b, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    tdpr_user_model i_tdpr_user_model (.aclk, .addr_a, .wdata_a, .we_a, .re_a,
        .addr_b, .wdata_b, .we_b, .re_b);

    // 50 MHz clock
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // hang guard: the whole run needs a few thousand cycles at most
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            end_sim();
        end
    end

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk

    // write: address and data offered together, each dropped when taken
    task axi_wr(input logic [11:0] a, input logic [31:0] wd);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        chk("bresp", `TDPR_RESP_OKAY, s_axi_bresp);
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task axi_rd(input logic [11:0] a, output logic [31:0] rd, output logic [1:0] rr);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    task t_reset;
        chk("q_a", 0, q_a);
        chk("q_b", 0, q_b);
        axi_rd(`TDPR_CTRL_OFS, d, r);
        chk("ctrl", `TDPR_CTRL_RST, d);
        chk("ctrl resp", `TDPR_RESP_OKAY, {30'h0, r});
        axi_rd(12'h00c, d, r);
        chk("unmapped resp", `TDPR_RESP_SLVERR, r);
        chk("unmapped data", 0, d);
    endtask : t_reset

    // mixed widths, two writes at once, read plus write at once
    task t_ports;
        i_tdpr_user_model.op(1, 0, 5, 16'h1234, 0, 0, 0, 0);
        i_tdpr_user_model.op(0, 1, 5, 0, 0, 1, 10, 0);
        chk("q_a", 16'h1234, q_a);
        chk("q_b low slice", 8'h34, q_b);
        i_tdpr_user_model.op(1, 0, 7, 16'h0f0f, 1, 0, 13, 8'hab);
        i_tdpr_user_model.op(0, 1, 7, 0, 1, 0, 12, 8'hcd);
        chk("q_a", 16'h0f0f, q_a);
        i_tdpr_user_model.op(0, 1, 6, 0, 0, 1, 11, 0);
        chk("q_a", 16'habcd, q_a);
        chk("q_b high slice", 8'h12, q_b);
    endtask : t_ports

    task t_rdw;
        i_tdpr_user_model.op(1, 1, 5, 16'h5555, 0, 1, 10, 0);
        chk("q_a old", 16'h1234, q_a);
        chk("q_b old", 8'h34, q_b);
        axi_wr(`TDPR_CTRL_OFS, 32'h2);
        i_tdpr_user_model.op(1, 1, 5, 16'haaaa, 0, 1, 10, 0);
        chk("q_a new", 16'haaaa, q_a);
        chk("q_b new", 8'haa, q_b);
    endtask : t_rdw

    // registered output lags one cycle, then an async clear of the output stages only
    task t_outreg;
        axi_wr(`TDPR_CTRL_OFS, 32'h1);
        i_tdpr_user_model.op(0, 1, 7, 0, 0, 0, 0, 0);
        chk("q_a lag", 16'haaaa, q_a);
        @(posedge aclk);
        #1;
        chk("q_a reg", 16'h0f0f, q_a);
        @(posedge aclk);
        out_clr <= 1'b1;
        #1;
        chk("q_a clr", 0, q_a);
        @(posedge aclk);
        #1;
        chk("q_b clr", 0, q_b);
        @(posedge aclk);
        out_clr <= 1'b0;
        // the latch was cleared too, so the first registered value is zero
        i_tdpr_user_model.op(0, 1, 7, 0, 0, 0, 0, 0);
        chk("q_a latch clr", 0, q_a);
        @(posedge aclk);
        #1;
        chk("q_a kept", 16'h0f0f, q_a);
    endtask : t_outreg

    task t_clash;
        axi_wr(`TDPR_CTRL_OFS, 32'h0);
        i_tdpr_user_model.clash_ok = 1'b1;
        i_tdpr_user_model.op(1, 0, 9, 16'h1111, 1, 0, 18, 8'h22);
        i_tdpr_user_model.clash_ok = 1'b0;
        axi_rd(`TDPR_STATUS_OFS, d, r);
        chk("collision", 1, d[`TDPR_STAT_COLL]);
        axi_wr(`TDPR_STATUS_OFS, 32'h1);
        axi_rd(`TDPR_STATUS_OFS, d, r);
        chk("collision cleared", 0, d[`TDPR_STAT_COLL]);
    endtask : t_clash

    task t_rom;
        axi_wr(`TDPR_CTRL_OFS, 32'h4);
        i_tdpr_user_model.op(1, 0, 6, 16'hdead, 1, 0, 12, 8'hee);
        i_tdpr_user_model.op(0, 1, 6, 0, 0, 1, 12, 0);
        chk("rom q_a", 16'habcd, q_a);
        chk("rom q_b", 8'hcd, q_b);
    endtask : t_rom

    // fill to the brim, one refused write, then drain and pop once past empty
    task t_fifo;
        axi_wr(`TDPR_CTRL_OFS, 32'hc);
        for (int i = 0; i < DEPTH; i++) begin
            i_tdpr_user_model.op(1, 0, 0, 16'(i) ^ 16'ha5c3, 0, 0, 0, 0);
        end
        axi_rd(`TDPR_COUNT_OFS, d, r);
        chk("fifo count full", DEPTH, d);
        axi_rd(`TDPR_STATUS_OFS, d, r);
        chk("fifo full", 1, d[`TDPR_STAT_FULL]);
        chk("fifo empty", 0, d[`TDPR_STAT_EMPTY]);
        // a write taken while full would land on the oldest entry
        i_tdpr_user_model.op(1, 0, 0, 16'hdead, 0, 0, 0, 0);
        i_tdpr_user_model.op(0, 0, 0, 0, 0, 1, 0, 0);
        chk("fifo first low", 8'hc3, q_b);
        i_tdpr_user_model.op(0, 0, 0, 0, 0, 1, 1, 0);
        chk("fifo second high", 8'ha5, q_b);
        for (int i = 2; i < DEPTH; i++) begin
            i_tdpr_user_model.op(0, 0, 0, 0, 0, 1, 0, 0);
        end
        chk("fifo last low", 8'(DEPTH - 1) ^ 8'hc3, q_b);
        i_tdpr_user_model.op(0, 0, 0, 0, 0, 1, 1, 0);
        chk("fifo pop empty", 8'(DEPTH - 1) ^ 8'hc3, q_b);
        axi_rd(`TDPR_STATUS_OFS, d, r);
        chk("fifo empty", 1, d[`TDPR_STAT_EMPTY]);
        axi_rd(`TDPR_COUNT_OFS, d, r);
        chk("fifo count", 0, d);
    endtask : t_fifo

    // shift use: tap n on port b reads the word written n+1 writes back
    task t_shift;
        axi_wr(`TDPR_CTRL_OFS, 32'h8);
        i_tdpr_user_model.op(1, 0, 0, 16'h3412, 0, 0, 0, 0);
        i_tdpr_user_model.op(1, 0, 0, 16'h7856, 0, 0, 0, 0);
        i_tdpr_user_model.op(0, 0, 0, 0, 0, 1, 3, 0);
        chk("tap 1 high", 8'h34, q_b);
        i_tdpr_user_model.op(0, 0, 0, 0, 0, 1, 0, 0);
        chk("tap 0 low", 8'h56, q_b);
        axi_rd(`TDPR_COUNT_OFS, d, r);
        chk("count outside fifo", 0, d);
    endtask : t_shift

    task end_sim;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    // reset for six cycles, then the scenarios in turn
    initial begin
        {failures, n_compared, cyc} = '0;
        {aresetn, out_clr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_ports();
        t_rdw();
        t_outreg();
        t_clash();
        t_rom();
        t_fifo();
        t_shift();
        end_sim();
    end
endmodule : tdpr_ram_test
